// ### chan_io_pkg.sv
// shared constants, types and timer tables for the channel output and pin block
package chan_io_pkg;

   localparam int N_CHAN = 4;
   localparam int N_PIN = 6;
   localparam int FILT_LEN = 4;

   // register offsets; per-channel registers repeat every CHAN_STRIDE
   localparam logic [7:0] LEAK_COMP_OFS = 8'h07;
   localparam logic [7:0] SWITCH_OUT_OFS = 8'h08;
   localparam logic [7:0] BURNOUT_OFS = 8'h09;
   localparam logic [7:0] SETPOINT_OFS = 8'h0a;
   localparam logic [7:0] LIVE_OFS = 8'h0c;
   localparam logic [7:0] CHAN_STRIDE = 8'h0c;
   localparam logic [7:0] PIN_CFG_OFS = 8'h32;
   localparam logic [7:0] PWR_OPT_OFS = 8'h38;

   // reset values
   localparam logic [15:0] LEAK_COMP_RST = 16'h0000;
   localparam logic [15:0] SWITCH_OUT_RST = 16'h1700;
   localparam logic [15:0] BURNOUT_RST = 16'h0000;
   localparam logic [15:0] SETPOINT_RST = 16'h0000;
   localparam logic [15:0] LIVE_RST = 16'h0000;
   localparam logic [15:0] PIN_CFG_RST = 16'h0008;
   localparam logic [15:0] PWR_OPT_RST = 16'h0000;

   // writable bit masks; reserved bits read as zero
   localparam logic [15:0] LEAK_COMP_MASK = 16'h0001;
   localparam logic [15:0] SWITCH_OUT_MASK = 16'h1fff;
   localparam logic [15:0] BURNOUT_MASK = 16'h0077;
   localparam logic [15:0] PIN_CFG_WR_MASK = 16'h00df;
   localparam logic [15:0] PWR_OPT_MASK = 16'h3fff;

   // field positions
   localparam int LEAK_ON_BIT = 0;
   localparam int SC_TIMER_LSB = 8;
   localparam int SW_DATA_BIT = 7;
   localparam int INRUSH_LSB = 2;
   localparam int SW_SRC_BIT = 1;
   localparam int SW_MODE_BIT = 0;
   localparam int TERM_POL_BIT = 0;
   localparam int TERM_CUR_LSB = 1;
   localparam int SENSE_POL_BIT = 4;
   localparam int SENSE_CUR_LSB = 5;
   localparam int PIN_ROUTE_LSB = 6;
   localparam int PIN_IN_BIT = 5;
   localparam int PIN_OUT_BIT = 4;
   localparam int PIN_PD_BIT = 3;
   localparam int PIN_FUNC_LSB = 0;

   localparam logic [4:0] INRUSH_BYPASS = 5'h00;
   localparam logic [4:0] SC_TIMER_OFF = 5'h1f;
   localparam logic [4:0] CODE_30 = 5'h1e;
   localparam logic [4:0] FLAT_LAST = 5'h07;

   typedef enum logic [2:0] {
      PIN_HIZ = 3'h0,
      PIN_OUT = 3'h1,
      PIN_IN = 3'h2,
      PIN_CMP = 3'h3,
      PIN_SWITCH = 3'h4
   } pin_func_t;

   // timing
   localparam longint unsigned CLK_HZ_DEFAULT = 64'd25000000;
   localparam longint unsigned NS_PER_S = 64'd1000000000;
   localparam longint unsigned STEP_NS [0:22] = '{
      64'd100812, 64'd130080, 64'd180486, 64'd240648, 64'd320322,
      64'd420321, 64'd560157, 64'd750399, 64'd1000803, 64'd1300800,
      64'd1800795, 64'd2400789, 64'd3200781, 64'd4200771, 64'd5600757,
      64'd7500738, 64'd10000713, 64'd13000683, 64'd18000633,
      64'd24000573, 64'd32000493, 64'd42000393, 64'd56000253};
   localparam longint unsigned INRUSH_30_NS = 64'd75000063;
   localparam longint unsigned LONGEST_NS = 64'd100000626;

   // duration of a timer code in ns; inrush differs only at code 30
   function automatic longint unsigned timer_ns(input logic [4:0] code,
                                                input logic inrush);
      longint unsigned r;
      if (code >= CODE_30) begin
         r = (inrush && code == CODE_30) ? INRUSH_30_NS : LONGEST_NS;
      end else if (code <= FLAT_LAST) begin
         r = STEP_NS[0];
      end else begin
         r = STEP_NS[int'(code) - int'(FLAT_LAST)];
      end
      return r;
   endfunction : timer_ns

   typedef struct packed {
      logic [31:0] inrush_cnt;
      logic [31:0] short_cnt;
      logic inrush_on;
      logic switch_on;
      logic leak_comp;
      logic timeout;
   } chan_stat_t;

   typedef struct packed {
      logic [N_CHAN-1:0][15:0] leak;
      logic [N_CHAN-1:0][15:0] sw;
      logic [N_CHAN-1:0][15:0] burn;
      logic [N_CHAN-1:0][15:0] setpoint;
      logic [N_CHAN-1:0][15:0] applied;
      logic [N_CHAN-1:0][15:0] live;
      chan_stat_t [N_CHAN-1:0] st;
      logic [N_PIN-1:0][15:0] pin;
      logic [15:0] pwr;
      logic [15:0] rdata;
      logic rvalid;
      logic [N_PIN-1:0] pin_out;
      logic [N_PIN-1:0] pin_oe;
   } regs_state_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic [FILT_LEN-1:0] hist;
      logic level;
   } filt_state_t;

endpackage : chan_io_pkg

// ### pin_filter.sv
// pin input synchroniser and glitch filter
`timescale 1ns/1ps
`default_nettype none
module pin_filter (
   input wire logic i_clk,  // system clock
   input wire logic i_srst, // synchronous reset
   input wire logic i_pin,  // raw pin level
   output logic o_level     // filtered level
);
   chan_io_pkg::filt_state_t s;
   chan_io_pkg::filt_state_t next_s;

   always_comb begin
      next_s = s;
      next_s.s1 = i_pin;
      next_s.s2 = s.s1;
      // extra stage keeps the pin-to-bit latency inside 8 to 10 clocks
      next_s.s3 = s.s2;
      next_s.hist = {s.hist[chan_io_pkg::FILT_LEN-2:0], s.s3};
      // level follows only after FILT_LEN equal samples
      if (&s.hist) begin
         next_s.level = 1'b1;
      end else if (~|s.hist) begin
         next_s.level = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_level = s.level;

   a_filter_stable: assert property (@(posedge i_clk) disable iff (i_srst)
      $changed(s.level) |-> $past(s.hist) == {chan_io_pkg::FILT_LEN{s.level}})
      else $error("filtered level changed without stable samples");

endmodule : pin_filter
`default_nettype wire

// ### channel_output_gpio_regs.sv
// per-channel switch driver, converter codes and pin config registers
//
// Contract
// - leakage compensation acts only while switch sourcing is disabled
// - compensation bit 0 enables the channel leakage compensation circuit
// - short circuit longer than timer field raises timeout and switches off
// - timer codes 0-7 100.812us, 8-30 rising, 31 disables the timer
// - inrush timer allows raised limit after turn-on; zero bypasses it
// - inrush codes: 0 bypass, 1-7 100.812us, 30 75ms, 31 100ms
// - driver source 0: software drive bit turns the switch on or off
// - driver source 1: switch driven by a pin configured for that channel
// - timeout clears the channel source-enable bit in hardware
// - source-enable set keeps leakage compensation off regardless
// - terminal burnout current two-bit field, bit 0 polarity
// - sense burnout current two-bit field, bit 4 polarity
// - setpoint is kept when the channel function changes
// - setpoint reaches converter at once, or on load when deferred
// - live value register returns the slewed code from i_live_code, not the applied code
// - routed pin modes pick channel A to D from a two-bit field
// - pin inputs synchronised, pulses under 4 clocks removed, 8-10 latency
// - pin function codes select hi-z, output, input, comparator, switch
// - software output mode drives the pin from output data bit 4
// - several pins sourcing one channel: highest pin index wins
`timescale 1ns/1ps
`default_nettype none
module channel_output_gpio_regs #(
   parameter longint unsigned CLK_HZ = chan_io_pkg::CLK_HZ_DEFAULT
) (
   input wire logic i_clk,                                // system clock
   input wire logic i_srst,                               // sync reset
   input wire logic i_wr,                                 // register write
   input wire logic i_rd,                                 // register read
   input wire logic [7:0] i_addr,                         // register offset
   input wire logic [15:0] i_wdata,                       // write data
   output logic [15:0] o_rdata,                           // read data
   output logic o_rvalid,                                 // read data valid
   input wire logic [3:0] i_deferred_update,              // per channel
   input wire logic i_converter_load,                     // load pulse
   input wire logic [3:0][15:0] i_live_code,              // slewed code
   input wire logic [3:0] i_short,                        // short detected
   input wire logic [3:0] i_comparator,                   // debounced cmp
   input wire logic [5:0] i_pin,                          // pin inputs
   output logic [5:0] o_pin_out,                          // pin out level
   output logic [5:0] o_pin_oe,                           // pin drive enable
   output logic [5:0] o_pin_pulldown,                     // weak pulldown
   output logic [5:0] o_pin_in_buf,                       // input buffer on
   output logic [3:0] o_switch_on,                        // switch drive
   output logic [3:0] o_inrush_limit,                     // raised limit
   output logic [3:0] o_timeout,                          // timeout pulse
   output logic [3:0] o_leak_comp,                        // leak comp on
   output logic [3:0][15:0] o_converter_code,             // applied code
   output logic [3:0][1:0] o_terminal_burn_current,       // terminal burn
   output logic [3:0] o_terminal_burn_polarity,           // 1 sources
   output logic [3:0][1:0] o_sense_burn_current,          // sense burn
   output logic [3:0] o_sense_burn_polarity,              // 1 sources
   output logic [13:0] o_power_optimise                   // buffer opt bits
);
   localparam int NC = chan_io_pkg::N_CHAN;
   localparam int NP = chan_io_pkg::N_PIN;

   chan_io_pkg::regs_state_t s;
   chan_io_pkg::regs_state_t next_s;
   logic [NP-1:0] pin_level;
   logic [NC-1:0] pin_drive;
   logic [NC-1:0] on_now;
   logic [NC-1:0] fire;

   function automatic logic [7:0] ch_addr(input logic [7:0] base,
                                          input int c);
      return 8'(int'(base) + int'(chan_io_pkg::CHAN_STRIDE) * c);
   endfunction : ch_addr

   // ns to clock cycles, rounded up, never below one
   function automatic logic [31:0] to_cycles(input longint unsigned ns);
      longint unsigned c;
      c = (ns * CLK_HZ + chan_io_pkg::NS_PER_S - 64'd1) /
          chan_io_pkg::NS_PER_S;
      if (c == 64'd0) begin
         c = 64'd1;
      end
      return 32'(c);
   endfunction : to_cycles

   function automatic logic in_buf_on(input logic [2:0] f);
      return f == chan_io_pkg::PIN_OUT || f == chan_io_pkg::PIN_IN ||
             f == chan_io_pkg::PIN_SWITCH;
   endfunction : in_buf_on

   ////////////////////////////////////////////////////////////////////////
   for (genvar p = 0; p < NP; p++) begin : g_pin
      pin_filter u_filter (
         .i_clk(i_clk),
         .i_srst(i_srst),
         .i_pin(i_pin[p]),
         .o_level(pin_level[p])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [4:0] t1;
      logic [4:0] t2;
      logic [2:0] f;
      logic [1:0] rc;
      logic req;
      t1 = '0;
      t2 = '0;
      f = '0;
      rc = '0;
      req = 1'b0;
      next_s = s;
      pin_drive = '0;
      on_now = '0;
      fire = '0;
      next_s.rvalid = i_rd;
      next_s.rdata = 16'h0000;
      for (int c = 0; c < NC; c++) begin
         next_s.live[c] = i_live_code[c];
      end

      // register reads; unmapped offsets return zero
      if (i_rd) begin
         for (int c = 0; c < NC; c++) begin
            if (i_addr == ch_addr(chan_io_pkg::LEAK_COMP_OFS, c))
               next_s.rdata = s.leak[c];
            if (i_addr == ch_addr(chan_io_pkg::SWITCH_OUT_OFS, c))
               next_s.rdata = s.sw[c];
            if (i_addr == ch_addr(chan_io_pkg::BURNOUT_OFS, c))
               next_s.rdata = s.burn[c];
            if (i_addr == ch_addr(chan_io_pkg::SETPOINT_OFS, c))
               next_s.rdata = s.setpoint[c];
            if (i_addr == ch_addr(chan_io_pkg::LIVE_OFS, c))
               next_s.rdata = s.live[c];
         end
         for (int p = 0; p < NP; p++) begin
            if (i_addr == 8'(int'(chan_io_pkg::PIN_CFG_OFS) + p))
               next_s.rdata = s.pin[p];
         end
         if (i_addr == chan_io_pkg::PWR_OPT_OFS)
            next_s.rdata = s.pwr;
      end

      // deferred load applies held setpoints; a direct write below wins
      if (i_converter_load) begin
         for (int c = 0; c < NC; c++) begin
            next_s.applied[c] = s.setpoint[c];
         end
      end

      // register writes; reserved bits are cleared, only pin config keeps its unwritable bits
      if (i_wr) begin
         for (int c = 0; c < NC; c++) begin
            if (i_addr == ch_addr(chan_io_pkg::LEAK_COMP_OFS, c))
               next_s.leak[c] = i_wdata & chan_io_pkg::LEAK_COMP_MASK;
            if (i_addr == ch_addr(chan_io_pkg::SWITCH_OUT_OFS, c))
               next_s.sw[c] = i_wdata & chan_io_pkg::SWITCH_OUT_MASK;
            if (i_addr == ch_addr(chan_io_pkg::BURNOUT_OFS, c))
               next_s.burn[c] = i_wdata & chan_io_pkg::BURNOUT_MASK;
            if (i_addr == ch_addr(chan_io_pkg::SETPOINT_OFS, c)) begin
               next_s.setpoint[c] = i_wdata;
               if (!i_deferred_update[c]) begin
                  next_s.applied[c] = i_wdata;
               end
            end
         end
         for (int p = 0; p < NP; p++) begin
            if (i_addr == 8'(int'(chan_io_pkg::PIN_CFG_OFS) + p))
               next_s.pin[p] = (i_wdata & chan_io_pkg::PIN_CFG_WR_MASK) |
                  (s.pin[p] & ~chan_io_pkg::PIN_CFG_WR_MASK);
         end
         if (i_addr == chan_io_pkg::PWR_OPT_OFS)
            next_s.pwr = i_wdata & chan_io_pkg::PWR_OPT_MASK;
      end

      // pins: input bit, drive, routing; later pins override earlier
      for (int p = 0; p < NP; p++) begin
         f = s.pin[p][chan_io_pkg::PIN_FUNC_LSB +: 3];
         rc = s.pin[p][chan_io_pkg::PIN_ROUTE_LSB +: 2];
         next_s.pin[p][chan_io_pkg::PIN_IN_BIT] =
            in_buf_on(f) & pin_level[p];
         case (f)
            chan_io_pkg::PIN_OUT: begin
               next_s.pin_oe[p] = 1'b1;
               next_s.pin_out[p] = s.pin[p][chan_io_pkg::PIN_OUT_BIT];
            end
            chan_io_pkg::PIN_CMP: begin
               next_s.pin_oe[p] = 1'b1;
               next_s.pin_out[p] = i_comparator[rc];
            end
            chan_io_pkg::PIN_SWITCH: begin
               next_s.pin_oe[p] = 1'b0;
               next_s.pin_out[p] = 1'b0;
               pin_drive[rc] = pin_level[p];
            end
            default: begin
               next_s.pin_oe[p] = 1'b0;
               next_s.pin_out[p] = 1'b0;
            end
         endcase
      end

      // per-channel switch driver and timers
      for (int c = 0; c < NC; c++) begin
         t1 = s.sw[c][chan_io_pkg::INRUSH_LSB +: 5];
         t2 = s.sw[c][chan_io_pkg::SC_TIMER_LSB +: 5];
         req = s.sw[c][chan_io_pkg::SW_SRC_BIT] ? pin_drive[c] :
               s.sw[c][chan_io_pkg::SW_DATA_BIT];
         on_now[c] = s.sw[c][chan_io_pkg::SW_MODE_BIT] & req;
         // inrush window restarts on every turn-on
         if (!on_now[c]) begin
            next_s.st[c].inrush_cnt = '0;
            next_s.st[c].inrush_on = 1'b0;
         end else if (!s.st[c].switch_on &&
                      t1 != chan_io_pkg::INRUSH_BYPASS) begin
            next_s.st[c].inrush_cnt =
               to_cycles(chan_io_pkg::timer_ns(t1, 1'b1));
            next_s.st[c].inrush_on = 1'b1;
         end else if (s.st[c].inrush_cnt > 32'h0000_0001) begin
            next_s.st[c].inrush_cnt = s.st[c].inrush_cnt - 32'h0000_0001;
         end else begin
            next_s.st[c].inrush_cnt = '0;
            next_s.st[c].inrush_on = 1'b0;
         end
         // short-circuit timer restarts on every new detection
         if (i_short[c] && s.st[c].switch_on && !s.st[c].inrush_on &&
             t2 != chan_io_pkg::SC_TIMER_OFF) begin
            next_s.st[c].short_cnt = s.st[c].short_cnt + 32'h0000_0001;
            fire[c] = (s.st[c].short_cnt + 32'h0000_0001) >=
               to_cycles(chan_io_pkg::timer_ns(t2, 1'b0));
         end else begin
            next_s.st[c].short_cnt = '0;
         end
         next_s.st[c].timeout = fire[c];
         if (fire[c]) begin
            next_s.sw[c][chan_io_pkg::SW_MODE_BIT] = 1'b0;
            next_s.st[c].short_cnt = '0;
         end
         next_s.st[c].switch_on = on_now[c] & ~fire[c];
         next_s.st[c].leak_comp = s.leak[c][chan_io_pkg::LEAK_ON_BIT] &
            ~s.sw[c][chan_io_pkg::SW_MODE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s <= '0;
         for (int c = 0; c < NC; c++) begin
            s.leak[c] <= chan_io_pkg::LEAK_COMP_RST;
            s.sw[c] <= chan_io_pkg::SWITCH_OUT_RST;
            s.burn[c] <= chan_io_pkg::BURNOUT_RST;
            s.setpoint[c] <= chan_io_pkg::SETPOINT_RST;
            s.applied[c] <= chan_io_pkg::SETPOINT_RST;
            s.live[c] <= chan_io_pkg::LIVE_RST;
         end
         for (int p = 0; p < NP; p++) begin
            s.pin[p] <= chan_io_pkg::PIN_CFG_RST;
         end
         s.pwr <= chan_io_pkg::PWR_OPT_RST;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign o_rdata = s.rdata;
   assign o_rvalid = s.rvalid;
   assign o_pin_out = s.pin_out;
   assign o_pin_oe = s.pin_oe;
   assign o_power_optimise = s.pwr[13:0];

   for (genvar p = 0; p < NP; p++) begin : g_pin_out
      assign o_pin_pulldown[p] = s.pin[p][chan_io_pkg::PIN_PD_BIT];
      assign o_pin_in_buf[p] = in_buf_on(s.pin[p][2:0]);
   end

   for (genvar c = 0; c < NC; c++) begin : g_chan_out
      assign o_switch_on[c] = s.st[c].switch_on;
      assign o_inrush_limit[c] = s.st[c].inrush_on;
      assign o_timeout[c] = s.st[c].timeout;
      assign o_leak_comp[c] = s.st[c].leak_comp;
      assign o_converter_code[c] = s.applied[c];
      assign o_terminal_burn_current[c] =
         s.burn[c][chan_io_pkg::TERM_CUR_LSB +: 2];
      assign o_terminal_burn_polarity[c] =
         s.burn[c][chan_io_pkg::TERM_POL_BIT];
      assign o_sense_burn_current[c] =
         s.burn[c][chan_io_pkg::SENSE_CUR_LSB +: 2];
      assign o_sense_burn_polarity[c] =
         s.burn[c][chan_io_pkg::SENSE_POL_BIT];

      a_leak_when_off: assert property (@(posedge i_clk) disable iff (i_srst)
         s.sw[c][0] |=> !o_leak_comp[c])
         else $error("leak compensation on while sourcing");
      a_leak_enable: assert property (@(posedge i_clk) disable iff (i_srst)
         (s.leak[c][0] && !s.sw[c][0]) |=> o_leak_comp[c])
         else $error("leak compensation not enabled");
      a_timeout_mode: assert property (@(posedge i_clk) disable iff (i_srst)
         o_timeout[c] |-> !s.sw[c][0] ##1 !o_switch_on[c])
         else $error("timeout left sourcing enabled");
      a_timer_off: assert property (@(posedge i_clk) disable iff (i_srst)
         o_timeout[c] |-> $past(s.sw[c][12:8]) != 5'h1f)
         else $error("disabled timer raised a timeout");
      a_inrush_masks: assert property (@(posedge i_clk) disable iff (i_srst)
         o_inrush_limit[c] |=> !o_timeout[c])
         else $error("timeout during inrush window");
      a_soft_drive: assert property (@(posedge i_clk) disable iff (i_srst)
         (s.sw[c][0] && !s.sw[c][1] && !i_short[c])
         |=> o_switch_on[c] == $past(s.sw[c][7]))
         else $error("switch does not follow drive bit");
      a_pin_drive: assert property (@(posedge i_clk) disable iff (i_srst)
         (s.sw[c][0] && s.sw[c][1] && !i_short[c])
         |=> o_switch_on[c] == $past(pin_drive[c]))
         else $error("switch does not follow routed pin");
      a_load_now: assert property (@(posedge i_clk) disable iff (i_srst)
         (i_wr && i_addr == ch_addr(chan_io_pkg::SETPOINT_OFS, c) &&
          !i_deferred_update[c])
         |=> o_converter_code[c] == $past(i_wdata))
         else $error("setpoint not applied at once");
      a_load_held: assert property (@(posedge i_clk) disable iff (i_srst)
         (i_wr && i_addr == ch_addr(chan_io_pkg::SETPOINT_OFS, c) &&
          i_deferred_update[c] && !i_converter_load)
         |=> $stable(o_converter_code[c]))
         else $error("deferred setpoint applied early");
   end

   for (genvar p = 0; p < NP; p++) begin : g_pin_chk
      a_pin_soft_out: assert property (@(posedge i_clk) disable iff (i_srst)
         (s.pin[p][2:0] == 3'h1) |=> o_pin_oe[p] &&
         o_pin_out[p] == $past(s.pin[p][4]))
         else $error("pin output does not follow data bit");
   end

endmodule : channel_output_gpio_regs
`default_nettype wire

// ### tb_channel_output_gpio_regs.sv
// self-checking bench for the channel output and pin register block
`timescale 1ns/1ps
`default_nettype none
module tb_channel_output_gpio_regs;
   logic i_clk = 0, i_srst = 1, i_wr = 0, i_rd = 0, i_converter_load = 0;
   logic [7:0] i_addr = 8'h00;
   logic [15:0] i_wdata = 16'h0000;
   logic [3:0] i_deferred_update = 4'h0, i_short = 4'h0, i_comparator = 4'h0;
   logic [3:0][15:0] i_live_code = '0;
   logic [5:0] i_pin = 6'h00;
   logic [15:0] o_rdata;
   logic o_rvalid;
   logic [5:0] o_pin_out, o_pin_oe, o_pin_pulldown, o_pin_in_buf;
   logic [3:0] o_switch_on, o_inrush_limit, o_timeout, o_leak_comp;
   logic [3:0][15:0] o_converter_code;
   logic [3:0][1:0] o_terminal_burn_current, o_sense_burn_current;
   logic [3:0] o_terminal_burn_polarity, o_sense_burn_polarity;
   logic [13:0] o_power_optimise;
   logic [15:0] mreg [0:63];
   logic [7:0] ra [8] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0c, 8'h32, 8'h38,
                          8'h01};
   logic [15:0] v, v2;
   logic oe, ib, ob;
   int seed = 39, n_fail = 0, cmp_count = 0, k;
   always #20 i_clk = ~i_clk;
   channel_output_gpio_regs #(.CLK_HZ(64'd25000)) i_channel_output_gpio_regs (
      .i_clk, .i_srst, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata, .o_rvalid,
      .i_deferred_update, .i_converter_load, .i_live_code, .i_short,
      .i_comparator, .i_pin, .o_pin_out, .o_pin_oe, .o_pin_pulldown,
      .o_pin_in_buf, .o_switch_on, .o_inrush_limit, .o_timeout, .o_leak_comp,
      .o_converter_code, .o_terminal_burn_current, .o_terminal_burn_polarity,
      .o_sense_burn_current, .o_sense_burn_polarity, .o_power_optimise);
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] wmask(input int a);
      if (a >= 8'h32 && a <= 8'h37) return chan_io_pkg::PIN_CFG_WR_MASK;
      if (a == 8'h38) return chan_io_pkg::PWR_OPT_MASK;
      if (a < 7 || a > 8'h2f) return 16'h0000;
      case ((a - 7) % 12)
         0: return chan_io_pkg::LEAK_COMP_MASK;
         1: return chan_io_pkg::SWITCH_OUT_MASK;
         2: return chan_io_pkg::BURNOUT_MASK;
         3: return 16'hffff;
         default: return 16'h0000;
      endcase
   endfunction : wmask
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge i_clk);
      i_wr = 1;
      i_addr = a;
      i_wdata = d;
      @(negedge i_clk);
      i_wr = 0;
      mreg[a] = (mreg[a] & ~wmask(a)) | (d & wmask(a));
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(negedge i_clk);
      i_rd = 1;
      i_addr = a;
      @(negedge i_clk);
      i_rd = 0;
      chk("rvalid", {15'h0, o_rvalid}, 16'h0001);
      chk("rdata", o_rdata, e);
   endtask : rd
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge i_clk);
      n_fail++;
      tally_and_finish();
   end
   initial begin
      for (int a = 0; a < 64; a++) mreg[a] = 16'h0000;
      for (int c = 0; c < 4; c++) mreg[8 + 12*c] = 16'h1700;
      for (int p = 0; p < 6; p++) mreg[8'h32 + p] = 16'h0008;
      i_comparator = 4'($random(seed));
      repeat (4) @(negedge i_clk);
      i_srst = 0;
      foreach (ra[j]) rd(ra[j], mreg[ra[j]]);
      chk("pulldown", {10'h0, o_pin_pulldown}, 16'h003f);
      for (int c = 0; c < 4; c++) begin
         wr(8'(7 + 12*c), 16'($random(seed)));
         wr(8'(9 + 12*c), 16'($random(seed)));
         wr(8'(12 + 12*c), 16'($random(seed)));
         v = mreg[9 + 12*c];
         rd(8'(7 + 12*c), mreg[7 + 12*c]);
         rd(8'(9 + 12*c), v);
         rd(8'(12 + 12*c), 16'h0000);
         v2 = {9'h0, o_sense_burn_current[c], o_sense_burn_polarity[c], 1'b0,
               o_terminal_burn_current[c], o_terminal_burn_polarity[c]};
         chk("burn", v2, v);
         chk("leak", 16'(o_leak_comp[c]), 16'(mreg[7 + 12*c][0]));
      end
      v = 16'($random(seed));
      wr(8'h38, v); // sequence field is never written afterwards
      chk("pwr_opt", {2'h0, o_power_optimise}, mreg[8'h38]);
      wr(8'h07, 16'h0001);
      wr(8'h08, 16'h0001);
      @(negedge i_clk);
      chk("leak_src", {15'h0, o_leak_comp[0]}, 16'h0000);
      wr(8'h08, 16'h0081);
      @(negedge i_clk);
      chk("sw_on", {15'h0, o_switch_on[0]}, 16'h0001);
      i_short[0] = 1'b1;
      k = 0;
      while (o_timeout[0] !== 1'b1 && k < 40) begin
         @(negedge i_clk);
         k++;
      end
      chk("t2_span", 16'(k), 16'h0003);
      chk("sw_cut", {15'h0, o_switch_on[0]}, 16'h0000);
      i_short = 4'h0;
      mreg[8] = 16'h0080;
      rd(8'h08, mreg[8]);
      // channel b: inrush code 1 holds off short timing for 3 cycles
      i_short[1] = 1'b1;
      wr(8'h14, 16'h0085);
      k = 0;
      v = 16'h0000;
      for (int n = 1; n <= 12; n++) begin
         @(negedge i_clk);
         k += int'(o_inrush_limit[1]);
         if (o_timeout[1] === 1'b1) v = 16'(n);
      end
      chk("inrush_len", 16'(k), 16'h0003);
      chk("inrush_t2", v, 16'h0007);
      i_short = 4'h0;
      rd(8'h14, 16'h0084);
      i_deferred_update = 4'h2;
      v = 16'($random(seed));
      v2 = 16'($random(seed));
      wr(8'h0a, v); // channel function never changes in this run
      wr(8'h16, v2);
      @(negedge i_clk);
      chk("dac_now", o_converter_code[0], v);
      chk("dac_held", o_converter_code[1], 16'h0000);
      i_converter_load = 1;
      @(negedge i_clk);
      i_converter_load = 0;
      @(negedge i_clk);
      chk("dac_load", o_converter_code[1], v2);
      i_live_code[2] = v2;
      repeat (2) @(negedge i_clk);
      rd(8'h24, v2);
      for (int f = 0; f < 8; f++) begin
         wr(8'h35, 16'h0010 | 16'(f) | (16'(f % 4) << 6));
         @(negedge i_clk);
         oe = (f == 1 || f == 3);
         ib = (f == 1 || f == 2 || f == 4);
         ob = (f == 1) ? 1'b1 : i_comparator[f % 4];
         v = {13'h0, o_pin_in_buf[3], o_pin_oe[3],
              o_pin_oe[3] & o_pin_out[3]};
         chk("pin", v, {13'h0, ib, oe, oe & ob});
      end
      wr(8'h08, 16'h0003);
      wr(8'h34, 16'h0004);
      wr(8'h37, 16'h0004);
      i_pin = 6'h20;
      k = 0;
      while (o_switch_on[0] !== 1'b1 && k < 20) begin
         @(negedge i_clk);
         k++;
      end
      chk("pin_lat", 16'(k >= 9 && k <= 11), 16'h0001);
      chk("pin_src", {15'h0, o_switch_on[0]}, 16'h0001);
      rd(8'h37, 16'h0024);
      i_pin = 6'h04;
      repeat (14) @(negedge i_clk);
      chk("pin_prio", {15'h0, o_switch_on[0]}, 16'h0000);
      i_pin = 6'h24;
      repeat (2) @(negedge i_clk);
      i_pin = 6'h04;
      repeat (14) @(negedge i_clk);
      rd(8'h37, 16'h0004);
      chk("pulldown", {10'h0, o_pin_pulldown}, 16'h0013);
      tally_and_finish();
   end
endmodule : tb_channel_output_gpio_regs
`default_nettype wire
